//--- rtl/sbr_pkg.sv
package sbr_pkg;
   // register byte offsets
   localparam logic [4:0] OFF_RATE = 5'h00;
   localparam logic [4:0] OFF_FLAGS = 5'h04;
   localparam logic [4:0] OFF_CTL1 = 5'h08;
   localparam logic [4:0] OFF_CTL2 = 5'h0C;
   localparam logic [4:0] OFF_DATA = 5'h10;
   // status bit positions
   localparam int RF_BIT = 7;
   localparam int TEF_BIT = 5;
   localparam int MF_BIT = 4;
   // control two bit position
   localparam int FEN_BIT = 4;
   // reset values
   localparam logic [7:0] RATE_RST = 8'h00;
   localparam logic [7:0] CTL1_RST = 8'h04;
   localparam logic [7:0] CTL2_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;

   // bit-rate register layout
   typedef struct packed {
      logic pad_hi;
      logic [2:0] prescale_select;
      logic pad_lo;
      logic [2:0] rate_divide_select;
   } sbr_rate_type;

   // control one layout
   typedef struct packed {
      logic irq_on;
      logic port_enable;
      logic transmit_irq_enable;
      logic master_select;
      logic clock_polarity;
      logic clock_phase;
      logic select_output_enable;
      logic lsb_first;
   } sbr_ctl_type;

   // bus answer states
   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_ANSWER = 1'b1
   } sbr_bus_type;
endpackage : sbr_pkg

//--- rtl/sbr_top.sv
`timescale 1ns/1ps
// Function
// RULE_01: bit-rate register accessible at any time
// RULE_02: prescaler divides bus clock by code plus one
// RULE_03: divider divides by two to code plus one
// RULE_04: prescaler output steps divider, divisors multiply
// RULE_05: status unused bits zero, writes ignored
// RULE_06: receive-full sets when transfer completes
// RULE_07: receive-full clears: flagged status read, data read
// RULE_08: transmit-empty clears: flagged status read, data write
// RULE_09: data write without flagged status read ignored
// RULE_10: transmit irq when empty flag and enable
// RULE_11: buffer-to-shifter move sets transmit-empty
// RULE_12: idle write reaches shifter, flag within two
// RULE_13: queued byte moves to shifter after transfer
// RULE_14: nothing queued: flag stays, nothing moves
// RULE_15: mode fault when master sees select low
// RULE_16: fault input only master, fault on, no output
// RULE_17: mode fault clears: flagged status read, control write
// RULE_18: port disable aborts, empties, resets flags; the code resets receive-full and transmit-empty but keeps mode fault
// RULE_19: master data write starts a transfer
// RULE_20: unread receive byte keeps, new byte dropped
module sbr_top
   import sbr_pkg::*;
#(
   parameter int ADDR_WIDTH = 5
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // avalon-mm slave
   input wire logic [ADDR_WIDTH-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // shifter side
   input wire logic xfer_done,
   input wire logic [7:0] rx_byte,
   output logic shift_load,
   output logic [7:0] shift_data,
   output logic master_start,
   output logic shift_abort,
   output logic bit_rate_tick,
   output sbr_ctl_type control_out,
   // slave-select pin, active low
   input wire logic select_in_n,
   // transmit request
   output logic transmit_irq
);

   // the address decoder needs the whole map
   if (ADDR_WIDTH < 5) begin : g_chk
      $error("sbr_top: ADDR_WIDTH below 5");
   end

   // true when a byte address hits a register word
   function automatic logic hit(input logic [ADDR_WIDTH-1:0] a,
                                input logic [4:0] off);
      hit = (a[ADDR_WIDTH-1:2] == (ADDR_WIDTH-2)'(off[4:2]));
   endfunction : hit

   // last count of the divider for a rate code
   function automatic logic [7:0] div_last(input logic [2:0] code);
      div_last = 8'((9'h002 << code) - 9'h001);
   endfunction : div_last

   // registers
   sbr_rate_type rate_q; // bit-rate register
   sbr_ctl_type ctl_q; // control one
   logic [7:0] ctl2_q; // control two
   logic [7:0] rxbuf_q; // receive buffer
   logic [7:0] txbuf_q; // transmit buffer
   logic txfull_q; // transmit buffer holds a byte
   logic busy_q; // shifter owns a byte
   logic rf_q; // receive_full_flag
   logic tef_q; // transmit_empty_flag
   logic mf_q; // mode_fault_flag
   logic rf_arm_q; // status read saw receive full
   logic tef_arm_q; // status read saw transmit empty
   logic mf_arm_q; // status read saw mode fault
   logic [2:0] pre_q; // prescaler count
   logic [7:0] div_q; // divider count
   logic tick_q; // bit-rate pulse
   sbr_bus_type bus_q; // bus answer state
   logic wait_q; // waitrequest flop
   logic [31:0] rdata_q; // captured read word
   logic load_q; // shifter load pulse
   logic start_q; // master start pulse
   logic abort_q; // abort level
   logic irq_q; // transmit request
   logic [7:0] sdata_q; // byte handed to shifter

   // decoded access strobes
   logic fire; // access completes this edge
   logic wr_rate, wr_ctl1, wr_ctl2, wr_data;
   logic rd_flags, rd_data;
   logic move; // buffer to shifter move
   logic fault; // mode fault condition
   logic pre_tick; // prescaler output pulse
   logic run; // bit-rate generator active
   logic [7:0] flags; // live status byte

   // a request completes on the edge that sees waitrequest low
   assign fire = (read | write) & ~wait_q;
   assign wr_rate = fire & write & byteenable[0] & hit(address, OFF_RATE);
   assign wr_ctl1 = fire & write & byteenable[0] & hit(address, OFF_CTL1);
   assign wr_ctl2 = fire & write & byteenable[0] & hit(address, OFF_CTL2);
   assign wr_data = fire & write & byteenable[0] & hit(address, OFF_DATA);
   assign rd_flags = fire & read & hit(address, OFF_FLAGS);
   assign rd_data = fire & read & hit(address, OFF_DATA);

   // status byte, unused positions tied low
   always_comb begin
      flags = 8'h00; // RULE_05
      flags[RF_BIT] = rf_q;
      flags[TEF_BIT] = tef_q;
      flags[MF_BIT] = mf_q;
   end

   // bus answer: one wait cycle, then done
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         bus_q <= BUS_IDLE;
         wait_q <= 1'b1;
      end else begin
         unique case (bus_q)
            BUS_IDLE: begin
               // grab the request, answer next cycle
               if (read | write) begin
                  bus_q <= BUS_ANSWER;
                  wait_q <= 1'b0;
               end
            end
            BUS_ANSWER: begin
               // access taken, back to waiting
               bus_q <= BUS_IDLE;
               wait_q <= 1'b1;
            end
         endcase
      end
   end

   // read word captured once, so arming matches what software saw
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rdata_q <= 32'h0000_0000;
      end else if (bus_q == BUS_IDLE && read) begin
         // rate readable even mid-transfer
         if (hit(address, OFF_RATE)) begin
            rdata_q <= {24'h000000, rate_q}; // RULE_01
         end else if (hit(address, OFF_FLAGS)) begin
            rdata_q <= {24'h000000, flags};
         end else if (hit(address, OFF_CTL1)) begin
            rdata_q <= {24'h000000, ctl_q};
         end else if (hit(address, OFF_CTL2)) begin
            rdata_q <= {24'h000000, ctl2_q};
         end else if (hit(address, OFF_DATA)) begin
            rdata_q <= {24'h000000, rxbuf_q};
         end else begin
            // unmapped reads as zero
            rdata_q <= 32'h0000_0000;
         end
      end
   end

   // software-written configuration; status has no write path
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rate_q <= RATE_RST;
         ctl_q <= CTL1_RST;
         ctl2_q <= CTL2_RST;
      end else begin
         // rate written whenever, reserved bits kept low
         if (wr_rate) begin
            rate_q <= writedata[7:0] & 8'h77; // RULE_01
         end
         if (wr_ctl1) begin
            ctl_q <= writedata[7:0];
         end
         if (wr_ctl2) begin
            ctl2_q <= writedata[7:0] & 8'h1B;
         end
      end
   end

   // generator runs only for an enabled master
   assign run = ctl_q.port_enable & ctl_q.master_select;
   assign pre_tick = run & (pre_q == rate_q.prescale_select);

   // prescaler: counts 0..code, a pulse every code+1 clocks
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pre_q <= 3'h0;
      end else if (!run || pre_tick) begin
         pre_q <= 3'h0; // RULE_02
      end else begin
         pre_q <= pre_q + 3'h1;
      end
   end

   // divider steps on prescaler pulses only, so rates multiply
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         div_q <= 8'h00;
         tick_q <= 1'b0;
      end else begin
         tick_q <= 1'b0;
         if (!run) begin
            div_q <= 8'h00;
         end else if (pre_tick) begin // RULE_04
            if (div_q >= div_last(rate_q.rate_divide_select)) begin
               div_q <= 8'h00; // RULE_03
               tick_q <= 1'b1;
            end else begin
               div_q <= div_q + 8'h01;
            end
         end
      end
   end

   // move when a byte waits and the shifter is free
   assign move = ctl_q.port_enable & txfull_q & ~busy_q & ~load_q;

   // transmit buffer and shifter ownership
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         txbuf_q <= DATA_RST;
         txfull_q <= 1'b0;
         busy_q <= 1'b0;
      end else if (!ctl_q.port_enable) begin
         // disable empties buffer and frees shifter
         txfull_q <= 1'b0; // RULE_18
         busy_q <= 1'b0;
      end else begin
         // only an armed write is queued
         if (wr_data && tef_arm_q) begin // RULE_09
            txbuf_q <= writedata[7:0];
            txfull_q <= 1'b1;
         end else if (move) begin
            txfull_q <= 1'b0; // RULE_13
         end
         // move claims the shifter, done releases it
         if (move) begin
            busy_q <= 1'b1;
         end else if (xfer_done) begin
            busy_q <= 1'b0; // RULE_14
         end
      end
   end

   // shifter handoff pulses
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         load_q <= 1'b0;
         start_q <= 1'b0;
         sdata_q <= DATA_RST;
         abort_q <= 1'b1;
      end else begin
         load_q <= move; // RULE_12
         start_q <= move & ctl_q.master_select; // RULE_19
         abort_q <= ~ctl_q.port_enable; // RULE_18
         if (move) begin
            sdata_q <= txbuf_q;
         end
      end
   end

   // transmit-empty: move sets, armed data write clears
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         tef_q <= 1'b1;
         tef_arm_q <= 1'b0;
      end else if (!ctl_q.port_enable) begin
         tef_q <= 1'b1; // RULE_18
         tef_arm_q <= 1'b0;
      end else begin
         // set wins over a clear in the same edge
         if (move) begin
            tef_q <= 1'b1; // RULE_11
         end else if (wr_data && tef_arm_q) begin
            tef_q <= 1'b0; // RULE_08
         end
         // arm on a status read that returned the flag set
         if (wr_data) begin
            tef_arm_q <= 1'b0;
         end else if (rd_flags && rdata_q[TEF_BIT]) begin
            tef_arm_q <= 1'b1; // RULE_08
         end
      end
   end

   // receive buffer and receive-full
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rxbuf_q <= DATA_RST;
         rf_q <= 1'b0;
         rf_arm_q <= 1'b0;
      end else if (!ctl_q.port_enable) begin
         rf_q <= 1'b0; // RULE_18
         rf_arm_q <= 1'b0;
      end else begin
         // an unread byte is kept; new one accepted if being read now
         if (xfer_done && (!rf_q || (rd_data && rf_arm_q))) begin
            rxbuf_q <= rx_byte; // RULE_20
         end
         // set wins over the clearing read
         if (xfer_done) begin
            rf_q <= 1'b1; // RULE_06
         end else if (rd_data && rf_arm_q) begin
            rf_q <= 1'b0; // RULE_07
         end
         if (rd_data) begin
            rf_arm_q <= 1'b0;
         end else if (rd_flags && rdata_q[RF_BIT]) begin
            rf_arm_q <= 1'b1; // RULE_07
         end
      end
   end

   // select pin is a fault input in one configuration only
   assign fault = ctl_q.port_enable & ctl_q.master_select & ctl2_q[FEN_BIT] &
                  ~ctl_q.select_output_enable & ~select_in_n; // RULE_15 RULE_16

   // mode fault flag; a fault still present re-sets it at once
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         mf_q <= 1'b0;
         mf_arm_q <= 1'b0;
      end else begin
         if (fault) begin
            mf_q <= 1'b1; // RULE_15
         end else if (wr_ctl1 && mf_arm_q) begin
            mf_q <= 1'b0; // RULE_17
         end
         if (wr_ctl1) begin
            mf_arm_q <= 1'b0;
         end else if (rd_flags && rdata_q[MF_BIT]) begin
            mf_arm_q <= 1'b1; // RULE_17
         end
      end
   end

   // transmit request follows flag and enable by one clock
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= tef_q & ctl_q.transmit_irq_enable; // RULE_10
      end
   end

   // outputs straight from flops
   assign readdata = rdata_q;
   assign waitrequest = wait_q;
   assign shift_load = load_q;
   assign shift_data = sdata_q;
   assign master_start = start_q;
   assign shift_abort = abort_q;
   assign bit_rate_tick = tick_q;
   assign control_out = ctl_q;
   assign transmit_irq = irq_q;

endmodule : sbr_top

//--- dv/sbr_assertions.sv
`timescale 1ns/1ps
// watches bus handshake, flag layout and shifter strobes at the top ports
module sbr_checker
   import sbr_pkg::*;
#(
   parameter int ADDR_WIDTH = 5
) (
   // clock and reset
   input logic clock,
   input logic reset,
   // register bus
   input logic [ADDR_WIDTH-1:0] address,
   input logic read,
   input logic write,
   input logic [31:0] readdata,
   input logic waitrequest,
   // shifter side
   input logic shift_load,
   input logic master_start,
   input logic shift_abort,
   input logic bit_rate_tick,
   input sbr_ctl_type control_out,
   input logic transmit_irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // a request is answered on the next edge or the one after
   chk_wait_answer: assert property ((read || write) && waitrequest |-> ##[1:2] !waitrequest)
      else $error("bus answer late");
   chk_wait_single: assert property (!waitrequest |=> waitrequest)
      else $error("wait low too long");
   chk_idle_wait: assert property (!read && !write && waitrequest |=> waitrequest)
      else $error("answer without request");
   chk_flags_zero: assert property (!waitrequest && read && address == OFF_FLAGS
      |-> readdata[31:8] == 24'h0 && !readdata[6] && readdata[3:0] == 4'h0)
      else $error("status spare bits set");
   chk_irq_enable: assert property (transmit_irq |-> $past(control_out.transmit_irq_enable))
      else $error("irq without enable");
   chk_start_load: assert property (master_start |-> shift_load)
      else $error("start without load");
   chk_load_pulse: assert property (shift_load |=> !shift_load)
      else $error("load pulse too long");
   chk_abort_off: assert property (!control_out.port_enable |-> ##[0:1] shift_abort)
      else $error("no abort while disabled");
   chk_tick_idle: assert property (!(control_out.port_enable && control_out.master_select) [*2]
      |-> !bit_rate_tick)
      else $error("tick while stopped");
   chk_tick_pulse: assert property (bit_rate_tick |=> !bit_rate_tick)
      else $error("tick too long");
   cover property (bit_rate_tick);
   cover property (master_start);
   cover property (transmit_irq);
endmodule : sbr_checker
bind sbr_top sbr_checker #(.ADDR_WIDTH(ADDR_WIDTH)) i_chk (.clock(clock), .reset(reset),
   .address(address), .read(read), .write(write), .readdata(readdata),
   .waitrequest(waitrequest), .shift_load(shift_load), .master_start(master_start),
   .shift_abort(shift_abort), .bit_rate_tick(bit_rate_tick), .control_out(control_out),
   .transmit_irq(transmit_irq));

//--- dv/sbr_shifter_model.sv
`timescale 1ns/1ps
// far-side shifter: eight bit ticks per master byte, a slow fixed span in slave mode
module sbr_shifter_model
   import sbr_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // from the block
   input wire logic shift_load,
   input wire logic master_start,
   input wire logic shift_abort,
   input wire logic bit_rate_tick,
   input wire logic [7:0] shift_data,
   // back to the block
   output logic xfer_done,
   output logic [7:0] rx_byte
);
   logic busy_q; // a byte is being shifted
   logic mst_q; // paced by bit ticks
   logic [7:0] hold_q; // byte being shifted
   int cnt_q; // bits or cycles so far
   // outside the done pulse the line shows the inverse, so stale data never matches
   assign rx_byte = xfer_done ? hold_q ^ 8'h5A : ~(hold_q ^ 8'h5A);
   // shift timing; an abort drops the byte in flight
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         busy_q <= 1'b0;
         mst_q <= 1'b0;
         hold_q <= 8'h00;
         cnt_q <= 0;
         xfer_done <= 1'b0;
      end else begin
         xfer_done <= 1'b0;
         if (shift_abort) begin
            busy_q <= 1'b0;
         end else if (shift_load) begin
            busy_q <= 1'b1;
            mst_q <= master_start;
            hold_q <= shift_data;
            cnt_q <= 0;
         end else if (busy_q && (!mst_q || bit_rate_tick)) begin
            cnt_q <= cnt_q + 1;
            if (cnt_q == (mst_q ? 7 : 39)) begin
               busy_q <= 1'b0;
               xfer_done <= 1'b1;
            end
         end
      end
   end
endmodule : sbr_shifter_model

//--- dv/sbr_top_tb.sv
`timescale 1ns/1ps
module sbr_top_tb;
   import sbr_pkg::*;
   logic clock, reset, read, write, select_in_n, waitrequest, xfer_done;
   logic shift_load, master_start, shift_abort, bit_rate_tick, transmit_irq, arm;
   logic [4:0] address;
   logic [31:0] writedata, readdata, q;
   logic [7:0] rx_byte, shift_data, d0, d1, r;
   sbr_ctl_type control_out;
   int n_mismatch = 0, check_count = 0, loads = 0, starts = 0, i;
   logic [7:0] txq[$]; // bytes the block should hand to the shifter, in order
   logic [7:0] c1s[3] = '{8'h50, 8'h52, 8'h40};
   logic [7:0] c2s[3] = '{8'h00, 8'h10, 8'h10};
   sbr_top i_dut (.clock(clock), .reset(reset), .address(address), .read(read),
      .write(write), .byteenable(4'h1), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .xfer_done(xfer_done), .rx_byte(rx_byte),
      .shift_load(shift_load), .shift_data(shift_data), .master_start(master_start),
      .shift_abort(shift_abort), .bit_rate_tick(bit_rate_tick), .control_out(control_out),
      .select_in_n(select_in_n), .transmit_irq(transmit_irq));
   sbr_shifter_model i_far (.clock(clock), .reset(reset), .shift_load(shift_load),
      .master_start(master_start), .shift_abort(shift_abort), .bit_rate_tick(bit_rate_tick),
      .shift_data(shift_data), .xfer_done(xfer_done), .rx_byte(rx_byte));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   task stop_test();
      if (n_mismatch == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test
   task chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // one bus access; request held until waitrequest is sampled low
   task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      int k;
      @(posedge clock);
      address <= a;
      read <= !w;
      write <= w;
      writedata <= {24'h0, d};
      k = 0;
      do begin @(posedge clock); k++; end while (waitrequest !== 1'b0 && k < 50);
      if (k >= 50) chk(32'h0, 32'h1);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      // model: a flagged status read arms the data write, which is used up once
      if (!w && a == OFF_FLAGS) arm = q[TEF_BIT];
      if (w && a == OFF_DATA) begin
         if (arm) txq.push_back(d);
         arm = 1'b0;
      end
   endtask : bus
   task rd(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 8'h00);
      chk(q, e);
   endtask : rd
   task wait_done();
      int k;
      k = 0;
      do begin @(posedge clock); k++; end while (xfer_done !== 1'b1 && k < 3000);
      // a transfer that never ends counts against the run
      if (k >= 3000) chk(32'h0, 32'h1);
      repeat (4) @(posedge clock);
   endtask : wait_done
   // cycles between two bit ticks
   task period(input int e);
      int k;
      k = 0;
      do begin @(posedge clock); k++; end while (bit_rate_tick !== 1'b1 && k < 5000);
      if (k >= 5000) chk(32'h0, 32'h1);
      k = 0;
      do begin @(posedge clock); k++; end while (bit_rate_tick !== 1'b1 && k < 5000);
      chk(k, e);
   endtask : period
   // every load must carry the next byte the model queued
   always @(posedge clock) begin
      if (!reset && shift_load === 1'b1) begin
         loads++;
         if (master_start === 1'b1) starts++;
         chk({24'h0, shift_data}, txq.size() ? {24'h0, txq.pop_front()} : 32'hX);
      end
   end
   initial begin
      repeat (80000) @(posedge clock);
      n_mismatch++;
      stop_test();
   end
   initial begin
      void'($urandom(32'h7F5E5BEA));
      // no request may stand while reset is applied
      {reset, read, write, arm} = 4'h8;
      address = 5'h00;
      writedata = 32'h0;
      select_in_n = 1'b1;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      d0 = 8'($urandom);
      d1 = 8'($urandom);
      rd(OFF_RATE, {24'h0, RATE_RST});
      bus(1'b1, OFF_CTL1, 8'h50);
      bus(1'b1, OFF_RATE, 8'h33);
      bus(1'b1, OFF_DATA, d0);
      repeat (8) @(posedge clock);
      chk(loads, 0);
      rd(OFF_FLAGS, 32'h20);
      bus(1'b1, OFF_DATA, d0);
      rd(OFF_FLAGS, 32'h20);
      bus(1'b1, OFF_DATA, d1);
      rd(OFF_FLAGS, 32'h00);
      wait_done();
      chk(loads, 2);
      rd(OFF_FLAGS, 32'hA0);
      wait_done();
      chk(loads, 2);
      rd(OFF_FLAGS, 32'hA0);
      rd(OFF_DATA, {24'h0, d0 ^ 8'h5A});
      rd(OFF_FLAGS, 32'h20);
      chk(starts, 2);
      bus(1'b1, OFF_FLAGS, 8'hFF);
      rd(OFF_FLAGS, 32'h20);
      rd(5'h14, 32'h0);
      // mode fault: only master, fault on, select output off
      bus(1'b1, OFF_CTL2, 8'h10);
      select_in_n <= 1'b0;
      repeat (2) @(posedge clock);
      select_in_n <= 1'b1;
      rd(OFF_FLAGS, 32'h30);
      bus(1'b1, OFF_CTL1, 8'h50);
      rd(OFF_FLAGS, 32'h20);
      for (i = 0; i < 3; i++) begin
         bus(1'b1, OFF_CTL1, c1s[i]);
         bus(1'b1, OFF_CTL2, c2s[i]);
         select_in_n <= 1'b0;
         rd(OFF_FLAGS, 32'h20);
         select_in_n <= 1'b1;
      end
      bus(1'b1, OFF_CTL2, 8'h00);
      bus(1'b1, OFF_CTL1, 8'h70);
      repeat (2) @(posedge clock);
      chk(transmit_irq, 1);
      chk({24'h0, control_out}, 32'h70);
      bus(1'b1, OFF_CTL1, 8'h50);
      repeat (2) @(posedge clock);
      chk(transmit_irq, 0);
      // disable with one byte shifting and one queued
      rd(OFF_FLAGS, 32'h20);
      bus(1'b1, OFF_DATA, d1);
      rd(OFF_FLAGS, 32'h20);
      bus(1'b1, OFF_DATA, d0);
      bus(1'b1, OFF_CTL1, 8'h10);
      txq.delete();
      // abort follows the control write by one registered stage
      repeat (2) @(posedge clock);
      chk(shift_abort, 1);
      rd(OFF_FLAGS, 32'h20);
      // slave mode: byte is preloaded but no master start
      bus(1'b1, OFF_CTL1, 8'h40);
      rd(OFF_FLAGS, 32'h20);
      bus(1'b1, OFF_DATA, d0);
      wait_done();
      chk(loads, 4);
      chk(starts, 3);
      rd(OFF_FLAGS, 32'hA0);
      rd(OFF_DATA, {24'h0, d0 ^ 8'h5A});
      bus(1'b1, OFF_CTL1, 8'h50);
      for (i = 0; i < 8; i++) begin
         r = (i == 0) ? 8'hFF : 8'($urandom);
         bus(1'b1, OFF_RATE, r);
         rd(OFF_RATE, {24'h0, r & 8'h77});
         period((int'(r[6:4]) + 1) * (2 << r[2:0]));
      end
      stop_test();
   end
endmodule : sbr_top_tb
